// ==== cscp_parser.v ====
// Purpose: ASCII line command parser for sensor configuration
// Assumes: Byte stream from a UART on the same clock, reply to a UART
// Notes:   One line at a time; input held off while replying
//
// The plain strobed port and the address map were decided locally.
`default_nettype none
`include "cscp_regs.vh"
// Operation
// - Lines and replies end with CR then LF; fields split by one space
// - Index 8 writes background high byte, index 9 the low byte
// - Background level is scaled by the configured value multiplier
// - Index 10 and 11 set fresh-air zero level high and low bytes
// - Altitude command stores decimal value, default 8192, range 0-65536
// - Altitude set replies with its letter and the stored number
// - Lowercase altitude query replies letter plus stored value
// - Interval command sets initial and regular intervals, echoes both
// - Interval arguments count in days
// - Interval command with single argument 0 disables auto-zero
// - Interval command without arguments reports current settings
// - Identity letter reports firmware string and serial number
// - Identity reply is two lines, each ended by CR LF
// - Altitude set is letter, space, decimal digits, terminator
module cscp_parser #(
  parameter [31:0] FW_TAG = 32'h56302E31,  // Arbitrary value
  parameter [16:0] SERIAL = 17'h00001      // Arbitrary value
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        ce,
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output reg         rx_ready_r,
  output reg  [7:0]  tx_data_r,
  output reg         tx_valid_r,
  input  wire        tx_ready,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata_r,
  output reg  [16:0] alt_r,
  output reg  [23:0] bg_ppm_r,
  output reg  [15:0] fa_ppm_r,
  output reg         az_en_r,
  output reg  [16:0] az_init_r,
  output reg  [16:0] az_reg_r
);
  localparam [2:0] S_CMD  = 3'h0;
  localparam [2:0] S_SEP  = 3'h1;
  localparam [2:0] S_ARG  = 3'h2;
  localparam [2:0] S_LF   = 3'h3;
  localparam [2:0] S_SKIP = 3'h4;
  localparam [2:0] S_CONV = 3'h5;
  localparam [2:0] S_SEND = 3'h6;

  reg  [2:0]   st_r;
  reg  [7:0]   cmd_r;
  reg  [1:0]   argc_r;
  reg          dig_r;
  reg          dot_r;
  reg  [1:0]   fcnt_r;
  reg  [1:0]   dots_r;
  reg  [3:0]   fr0_r;
  reg  [3:0]   fr1_r;
  reg  [7:0]   bg_hi_r;
  reg  [7:0]   bg_lo_r;
  reg  [7:0]   fa_hi_r;
  reg  [7:0]   fa_lo_r;
  reg  [7:0]   mult_r;
  reg  [3:0]   azi_fr_r;
  reg  [3:0]   azr_fr_r;
  reg  [2:0]   typ_r;
  reg  [16:0]  fa_val_r;
  reg  [16:0]  fb_val_r;
  reg  [4:0]   idx_r;
  reg  [4:0]   len_r;
  reg          conv_go_r;
  reg  [183:0] msg;
  wire         take;
  wire         is_dig;
  wire         acc_clr;
  wire [16:0]  a0;
  wire [16:0]  a1;
  wire         ovf0;
  wire         ovf1;
  wire [19:0]  bcd_a;
  wire [19:0]  bcd_b;
  wire         done_a;
  wire         done_b;
  wire [39:0]  asc_a;
  wire [39:0]  asc_b;
  wire         arg_ok;

  assign take    = rx_valid & rx_ready_r;
  assign is_dig  = (rx_data >= 8'h30) && (rx_data <= 8'h39);
  assign acc_clr = (st_r == S_CMD);
  // Closing a field: digits present, tenths digit count exact if point
  assign arg_ok  = dig_r && (!dot_r || (fcnt_r == 2'h1));

  cscp_acc u_acc0 (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .clr   (acc_clr),
    .en    (take && st_r == S_ARG && is_dig && argc_r == 2'h1 && !dot_r),
    .digit (rx_data[3:0]),
    .val_r (a0),
    .ovf_r (ovf0)
  );

  cscp_acc u_acc1 (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .clr   (acc_clr),
    .en    (take && st_r == S_ARG && is_dig && argc_r == 2'h2 && !dot_r),
    .digit (rx_data[3:0]),
    .val_r (a1),
    .ovf_r (ovf1)
  );

  cscp_b2d u_b2d_a (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .start  (conv_go_r),
    .bin    (fa_val_r),
    .bcd_r  (bcd_a),
    .done_r (done_a)
  );

  cscp_b2d u_b2d_b (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .start  (conv_go_r),
    .bin    (fb_val_r),
    .bcd_r  (bcd_b),
    .done_r (done_b)
  );

  // Five zero-padded ASCII digits per field
  assign asc_a = {4'h3, bcd_a[19:16], 4'h3, bcd_a[15:12], 4'h3, bcd_a[11:8],
                  4'h3, bcd_a[7:4], 4'h3, bcd_a[3:0]};
  assign asc_b = {4'h3, bcd_b[19:16], 4'h3, bcd_b[15:12], 4'h3, bcd_b[11:8],
                  4'h3, bcd_b[7:4], 4'h3, bcd_b[3:0]};

  // Reply image, first byte in the top bits
  always @* begin
    case (typ_r)
      `CSCP_T_P:
        msg = {`CSCP_CH_P, `CSCP_SP, asc_a, `CSCP_SP, asc_b,
               `CSCP_CR, `CSCP_LF, 64'h0};
      `CSCP_T_S:
        msg = {cmd_r, `CSCP_SP, asc_a, `CSCP_CR, `CSCP_LF,
               112'h0};
      `CSCP_T_AZ:
        msg = {`CSCP_CH_AT, `CSCP_SP, asc_a, `CSCP_DOT, 4'h3, azi_fr_r,
               `CSCP_SP, asc_b, `CSCP_DOT, 4'h3, azr_fr_r,
               `CSCP_CR, `CSCP_LF, 32'h0};
      `CSCP_T_OFF:
        msg = {`CSCP_CH_AT, `CSCP_SP, `CSCP_ZERO, `CSCP_CR, `CSCP_LF,
               144'h0};
      `CSCP_T_Y:
        msg = {`CSCP_CH_Y, `CSCP_COMMA, FW_TAG, `CSCP_CR, `CSCP_LF,
               `CSCP_CH_B, `CSCP_SP, asc_a, `CSCP_SP, `CSCP_ZERO,
               `CSCP_ZERO, `CSCP_ZERO, `CSCP_ZERO, `CSCP_ZERO,
               `CSCP_CR, `CSCP_LF};
      default:
        msg = 184'h0;
    endcase
  end

  // Line parser, command execution and reply sender
  always @(posedge mclk) begin
    if (rst) begin
      st_r       <= S_CMD;
      cmd_r      <= 8'h00;
      argc_r     <= 2'h0;
      dig_r      <= 1'b0;
      dot_r      <= 1'b0;
      fcnt_r     <= 2'h0;
      dots_r     <= 2'h0;
      fr0_r      <= 4'h0;
      fr1_r      <= 4'h0;
      bg_hi_r    <= `CSCP_BG_HI_RST;
      bg_lo_r    <= `CSCP_BG_LO_RST;
      fa_hi_r    <= `CSCP_FA_HI_RST;
      fa_lo_r    <= `CSCP_FA_LO_RST;
      alt_r      <= `CSCP_ALT_RST;
      az_en_r    <= 1'b1;
      az_init_r  <= `CSCP_AZI_RST;
      az_reg_r   <= `CSCP_AZR_RST;
      azi_fr_r   <= 4'h0;
      azr_fr_r   <= 4'h0;
      typ_r      <= `CSCP_T_S;
      fa_val_r   <= 17'h00000;
      fb_val_r   <= 17'h00000;
      idx_r      <= 5'h00;
      len_r      <= 5'h00;
      conv_go_r  <= 1'b0;
      rx_ready_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (ce) begin
      conv_go_r <= 1'b0;
      case (st_r)
        S_CMD: begin
          rx_ready_r <= 1'b1;
          argc_r     <= 2'h0;
          dig_r      <= 1'b0;
          dot_r      <= 1'b0;
          fcnt_r     <= 2'h0;
          dots_r     <= 2'h0;
          if (take) begin
            cmd_r <= rx_data;
            st_r  <= S_SEP;
          end
        end
        S_SEP: begin
          if (take) begin
            if (rx_data == `CSCP_SP) begin
              argc_r <= 2'h1;
              st_r   <= S_ARG;
            end else if (rx_data == `CSCP_CR)
              st_r <= S_LF;
            else
              st_r <= S_SKIP;
          end
        end
        S_ARG: begin
          if (take) begin
            if (is_dig) begin
              dig_r <= 1'b1;
              if (dot_r) begin
                fcnt_r <= fcnt_r + 2'h1;
                if (fcnt_r != 2'h0)
                  st_r <= S_SKIP;
                else if (argc_r == 2'h1)
                  fr0_r <= rx_data[3:0];
                else
                  fr1_r <= rx_data[3:0];
              end
            end else if (rx_data == `CSCP_DOT) begin
              if (dot_r || !dig_r)
                st_r <= S_SKIP;
              else begin
                dot_r  <= 1'b1;
                dots_r <= dots_r | argc_r;
              end
            end else if (rx_data == `CSCP_SP) begin
              if (!arg_ok || argc_r == 2'h2)
                st_r <= S_SKIP;
              else begin
                argc_r <= 2'h2;
                dig_r  <= 1'b0;
                dot_r  <= 1'b0;
                fcnt_r <= 2'h0;
              end
            end else if (rx_data == `CSCP_CR)
              st_r <= arg_ok ? S_LF : S_SKIP;
            else
              st_r <= S_SKIP;
          end
        end
        S_LF: begin
          if (take) begin
            st_r <= S_CMD;
            if (rx_data == `CSCP_LF) begin
              case (cmd_r)
                `CSCP_CH_P: begin
                  if (argc_r == 2'h2 && dots_r == 2'h0 && !ovf0 && !ovf1 &&
                      a1 <= `CSCP_BYTE_MAX && a0 >= `CSCP_IDX_BG_HI &&
                      a0 <= `CSCP_IDX_FA_LO) begin
                    if (a0 == `CSCP_IDX_BG_HI)
                      bg_hi_r <= a1[7:0];
                    if (a0 == `CSCP_IDX_BG_LO)
                      bg_lo_r <= a1[7:0];
                    if (a0 == `CSCP_IDX_FA_HI)
                      fa_hi_r <= a1[7:0];
                    if (a0 == `CSCP_IDX_FA_LO)
                      fa_lo_r <= a1[7:0];
                    typ_r    <= `CSCP_T_P;
                    fa_val_r <= a0;
                    fb_val_r <= a1;
                    st_r     <= S_CONV;
                  end
                end
                `CSCP_CH_S: begin
                  if (argc_r == 2'h1 && dots_r == 2'h0 && !ovf0 &&
                      a0 <= `CSCP_ALT_MAX) begin
                    alt_r    <= a0;
                    typ_r    <= `CSCP_T_S;
                    fa_val_r <= a0;
                    st_r     <= S_CONV;
                  end
                end
                `CSCP_CH_SL: begin
                  if (argc_r == 2'h0) begin
                    typ_r    <= `CSCP_T_S;
                    fa_val_r <= alt_r;
                    st_r     <= S_CONV;
                  end
                end
                `CSCP_CH_AT: begin
                  if (argc_r == 2'h0) begin
                    typ_r    <= az_en_r ? `CSCP_T_AZ : `CSCP_T_OFF;
                    fa_val_r <= az_init_r;
                    fb_val_r <= az_reg_r;
                    st_r     <= S_CONV;
                  end else if (argc_r == 2'h1 && dots_r == 2'h0 &&
                               !ovf0 && a0 == 17'h00000) begin
                    az_en_r <= 1'b0;
                    typ_r   <= `CSCP_T_OFF;
                    st_r    <= S_CONV;
                  end else if (argc_r == 2'h2 && dots_r == 2'h3 &&
                               !ovf0 && !ovf1) begin
                    az_en_r   <= 1'b1;
                    az_init_r <= a0;
                    az_reg_r  <= a1;
                    azi_fr_r  <= fr0_r;
                    azr_fr_r  <= fr1_r;
                    typ_r     <= `CSCP_T_AZ;
                    fa_val_r  <= a0;
                    fb_val_r  <= a1;
                    st_r      <= S_CONV;
                  end
                end
                `CSCP_CH_Y: begin
                  if (argc_r == 2'h0) begin
                    typ_r    <= `CSCP_T_Y;
                    fa_val_r <= SERIAL;
                    st_r     <= S_CONV;
                  end
                end
                default: st_r <= S_CMD;
              endcase
              if (st_r == S_LF)
                conv_go_r <= 1'b1;
            end
          end
        end
        S_SKIP: begin
          if (take && rx_data == `CSCP_LF)
            st_r <= S_CMD;
        end
        S_CONV: begin
          rx_ready_r <= 1'b0;
          idx_r      <= 5'h00;
          case (typ_r)
            `CSCP_T_P:   len_r <= `CSCP_LEN_P;
            `CSCP_T_AZ:  len_r <= `CSCP_LEN_AZ;
            `CSCP_T_OFF: len_r <= `CSCP_LEN_OFF;
            `CSCP_T_Y:   len_r <= `CSCP_LEN_Y;
            default:     len_r <= `CSCP_LEN_S;
          endcase
          if (!conv_go_r && done_a && done_b)
            st_r <= S_SEND;
        end
        S_SEND: begin
          if (!tx_valid_r || tx_ready) begin
            if (idx_r == len_r) begin
              tx_valid_r <= 1'b0;
              st_r       <= S_CMD;
            end else begin
              tx_valid_r <= 1'b1;
              tx_data_r  <= msg[183 - 8 * idx_r -: 8];
              idx_r      <= idx_r + 5'h01;
            end
          end
        end
        default: st_r <= S_CMD;
      endcase
      // Input closed from each line feed accepted in S_LF until any reply is sent
      if (st_r == S_CONV || st_r == S_SEND)
        rx_ready_r <= 1'b0;
      if (take && rx_data == `CSCP_LF && st_r == S_LF)
        rx_ready_r <= 1'b0;
    end
  end

  // Level outputs and register port
  always @(posedge mclk) begin
    if (rst) begin
      mult_r   <= `CSCP_MULT_RST;
      bg_ppm_r <= 24'h000000;
      fa_ppm_r <= 16'h0000;
      rdata_r  <= 32'h00000000;
    end else if (ce) begin
      bg_ppm_r <= {bg_hi_r, bg_lo_r} * mult_r;
      fa_ppm_r <= {fa_hi_r, fa_lo_r};
      if (wr && addr == `CSCP_OFS_CTRL)
        mult_r <= wdata[7:0];
      if (rd) begin
        case (addr)
          `CSCP_OFS_CTRL: rdata_r <= {24'h000000, mult_r};
          `CSCP_OFS_ALT:  rdata_r <= {15'h0000, alt_r};
          `CSCP_OFS_BG:   rdata_r <= {16'h0000, bg_hi_r, bg_lo_r};
          `CSCP_OFS_BGS:  rdata_r <= {8'h00, bg_ppm_r};
          `CSCP_OFS_FA:   rdata_r <= {16'h0000, fa_hi_r, fa_lo_r};
          `CSCP_OFS_AZI:  rdata_r <= {4'h0, azi_fr_r, 7'h00, az_init_r};
          `CSCP_OFS_AZR:  rdata_r <= {4'h0, azr_fr_r, 7'h00, az_reg_r};
          `CSCP_OFS_STAT: rdata_r <= {28'h0000000, 1'b0, st_r == S_SEND,
                                      st_r == S_CONV, az_en_r};
          default:        rdata_r <= 32'h00000000;
        endcase
      end else
        rdata_r <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ==== cscp_regs.vh ====
// Purpose: Constants for the sensor configuration command parser
// Assumes: Included by the parser design files only
// Notes:   Offsets are byte addresses on the plain register port
`ifndef CSCP_REGS_VH
`define CSCP_REGS_VH

// ASCII codes
`define CSCP_CR        8'h0D
`define CSCP_LF        8'h0A
`define CSCP_SP        8'h20
`define CSCP_DOT       8'h2E
`define CSCP_COMMA     8'h2C
`define CSCP_ZERO      8'h30
`define CSCP_CH_P      8'h50
`define CSCP_CH_S      8'h53
`define CSCP_CH_SL     8'h73
`define CSCP_CH_AT     8'h40
`define CSCP_CH_Y      8'h59
`define CSCP_CH_B      8'h42

// Parameter indexes
`define CSCP_IDX_BG_HI 17'h00008
`define CSCP_IDX_BG_LO 17'h00009
`define CSCP_IDX_FA_HI 17'h0000A
`define CSCP_IDX_FA_LO 17'h0000B
`define CSCP_BYTE_MAX  17'h000FF

// Numeric limits
`define CSCP_NUM_MAX   21'h010000
`define CSCP_ALT_MAX   17'h10000

// Reset values
`define CSCP_ALT_RST   17'h02000
`define CSCP_BG_HI_RST 8'h01
`define CSCP_BG_LO_RST 8'h90
`define CSCP_FA_HI_RST 8'h01
`define CSCP_FA_LO_RST 8'h90
`define CSCP_MULT_RST  8'h01
`define CSCP_AZI_RST   17'h00001
`define CSCP_AZR_RST   17'h00008

// Register offsets
`define CSCP_OFS_CTRL  8'h00
`define CSCP_OFS_ALT   8'h04
`define CSCP_OFS_BG    8'h08
`define CSCP_OFS_BGS   8'h0C
`define CSCP_OFS_FA    8'h10
`define CSCP_OFS_AZI   8'h14
`define CSCP_OFS_AZR   8'h18
`define CSCP_OFS_STAT  8'h1C

// Interval register field: tenths digit position
`define CSCP_FRAC_LSB  24

// Reply types and lengths in bytes
`define CSCP_T_P       3'h0
`define CSCP_T_S       3'h1
`define CSCP_T_AZ      3'h2
`define CSCP_T_OFF     3'h3
`define CSCP_T_Y       3'h4
`define CSCP_LEN_P     5'h0F
`define CSCP_LEN_S     5'h09
`define CSCP_LEN_AZ    5'h13
`define CSCP_LEN_OFF   5'h05
`define CSCP_LEN_Y     5'h17

// Binary to decimal shift count
`define CSCP_B2D_BITS  5'h11

`endif

// ==== cscp_acc.v ====
// Purpose: Decimal digit accumulator for one numeric argument
// Assumes: Digits arrive one per enable, most significant first
// Notes:   Overflow flags any value above 65536
`default_nettype none
`include "cscp_regs.vh"
module cscp_acc (
  input  wire        mclk,
  input  wire        rst,
  input  wire        ce,
  input  wire        clr,
  input  wire        en,
  input  wire [3:0]  digit,
  output reg  [16:0] val_r,
  output reg         ovf_r
);
  wire [20:0] val_nxt;

  assign val_nxt = {4'h0, val_r} * 21'h00000A + {17'h00000, digit};

  always @(posedge mclk) begin
    if (rst) begin
      val_r <= 17'h00000;
      ovf_r <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        val_r <= 17'h00000;
        ovf_r <= 1'b0;
      end else if (en) begin
        val_r <= val_nxt[16:0];
        if (val_nxt > `CSCP_NUM_MAX)
          ovf_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== cscp_b2d.v ====
// Purpose: Serial binary to five digit BCD converter
// Assumes: Input below 100000
// Notes:   Result ready 17 cycles after start
`default_nettype none
`include "cscp_regs.vh"
module cscp_b2d (
  input  wire        mclk,
  input  wire        rst,
  input  wire        ce,
  input  wire        start,
  input  wire [16:0] bin,
  output reg  [19:0] bcd_r,
  output reg         done_r
);
  reg  [16:0] sh_r;
  reg  [4:0]  cnt_r;
  reg         busy_r;
  wire [19:0] adj;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : adj_g
      assign adj[4*g+3:4*g] = (bcd_r[4*g+3:4*g] >= 4'h5) ?
                              bcd_r[4*g+3:4*g] + 4'h3 :
                              bcd_r[4*g+3:4*g];
    end
  endgenerate

  always @(posedge mclk) begin
    if (rst) begin
      sh_r   <= 17'h00000;
      bcd_r  <= 20'h00000;
      cnt_r  <= 5'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      if (start) begin
        sh_r   <= bin;
        bcd_r  <= 20'h00000;
        cnt_r  <= `CSCP_B2D_BITS;
        busy_r <= 1'b1;
        done_r <= 1'b0;
      end else if (busy_r) begin
        bcd_r <= {adj[18:0], sh_r[16]};
        sh_r  <= {sh_r[15:0], 1'b0};
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== cscp_host.sv ====
// Purpose: Host side model: sends command lines, collects reply bytes
// Assumes: Same clock as the parser; lines sent one at a time
// Notes:   slow set by the bench makes the sink stall every other cycle
`default_nettype none
module cscp_host (
  input  wire logic       mclk,
  input  wire logic       rst,
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  input  wire logic       rx_ready_r,
  input  wire logic [7:0] tx_data_r,
  input  wire logic       tx_valid_r,
  output var  logic       tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic       slow;
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end
  // Byte held until the edge where ready is seen high
  task automatic send_line(input string s, output bit hung);
    string t;
    int    n;
    hung = 1'b0;
    t = {s, "\015\012"};
    for (int i = 0; i < t.len() && !hung; i++) begin
      rx_data  <= t[i];
      rx_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!rx_ready_r && n < 500);
      hung = !rx_ready_r;
    end
    rx_valid <= 1'b0;
    rx_data  <= ~t[t.len()-1];
  endtask
  // Reply sink, optionally stalling
  always @(posedge mclk) begin
    if (tx_valid_r && tx_ready && !rst)
      got.push_back(tx_data_r);
    tx_ready <= rst ? 1'b0 : (slow ? ~tx_ready : 1'b1);
  end
endmodule
`default_nettype wire

// ==== cscp_parser_properties.sv ====
// Purpose: Port checker for the command parser
// Assumes: ce held high by the bench except during one register write
// Notes:   Bound to the parser from the bench top file
`default_nettype none
module cscp_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        rx_ready_r,
  input wire logic [7:0]  tx_data_r,
  input wire logic        tx_valid_r,
  input wire logic        tx_ready,
  input wire logic [7:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata_r,
  input wire logic [16:0] alt_r,
  input wire logic        az_en_r,
  input wire logic [16:0] az_init_r,
  input wire logic [16:0] az_reg_r
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_TX_HOLD: assert property (
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
    else $error("reply byte dropped before taken");
  AST_TX_END_LF: assert property (
    $fell(tx_valid_r) |-> $past(tx_data_r) == 8'h0A)
    else $error("reply did not end with line feed");
  AST_TX_LETTER: assert property (
    $rose(tx_valid_r) |->
      tx_data_r inside {8'h50, 8'h53, 8'h73, 8'h40, 8'h59})
    else $error("reply starts with wrong letter");
  AST_RX_BACK: assert property (
    $fell(tx_valid_r) |-> ##[0:3] rx_ready_r)
    else $error("input not reopened after reply");
  AST_NO_RX_IN_TX: assert property (
    tx_valid_r |-> !rx_ready_r)
    else $error("input open while replying");
  AST_RD_IDLE: assert property (
    !rd |=> rdata_r == 32'h00000000)
    else $error("read data not zero outside read");
  AST_RD_ALT: assert property (
    rd && addr == 8'h04 |=> rdata_r == {15'h0000, $past(alt_r)})
    else $error("altitude read mismatch");
  AST_RD_AZEN: assert property (
    rd && addr == 8'h1C |=> rdata_r[0] == $past(az_en_r))
    else $error("auto-zero enable read mismatch");
  AST_ALT_RANGE: assert property (
    alt_r <= 17'h10000)
    else $error("altitude above range");
  AST_RST_VAL: assert property (
    $fell(rst) |-> alt_r == 17'h02000 && az_init_r == 17'h00001
      && az_reg_r == 17'h00008 && az_en_r)
    else $error("reset values wrong");
  COV_REPLY: cover property ($rose(tx_valid_r));
  COV_AZ_OFF: cover property ($fell(az_en_r));
  COV_ALT_RD: cover property (rd && addr == 8'h04);
endmodule
`default_nettype wire

// ==== test_sensor_config_command_parser.sv ====
// Purpose: Self-checking bench for the command parser
// Assumes: Host model drives the byte link, bench the register port
// Notes:   ce high except during one register write; identity values arbitrary
`default_nettype none
module test_sensor_config_command_parser;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  wire  [7:0]  rx_data, tx_data_r;
  wire         rx_valid, rx_ready_r, tx_valid_r, tx_ready;
  wire  [31:0] rdata_r;
  wire  [16:0] alt_r, az_init_r, az_reg_r;
  wire  [23:0] bg_ppm_r;
  wire  [15:0] fa_ppm_r;
  wire         az_en_r;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [31:0] d;
  always #25 mclk = ~mclk;
  cscp_parser #(.FW_TAG(32'h54322E30), .SERIAL(17'h00037)) dut_u (
    .mclk(mclk), .rst(rst), .ce(ce), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready_r(rx_ready_r), .tx_data_r(tx_data_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .alt_r(alt_r),
    .bg_ppm_r(bg_ppm_r), .fa_ppm_r(fa_ppm_r), .az_en_r(az_en_r),
    .az_init_r(az_init_r), .az_reg_r(az_reg_r));
  cscp_host host_u (
    .mclk(mclk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready_r(rx_ready_r), .tx_data_r(tx_data_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready));
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    v = rdata_r;
  endtask
  // Send a line, wait for the reply or for silence, compare bytes
  task automatic cmd(input string s, input string r);
    int n;
    bit hung;
    if (r.len() > 0) r = {r, "\015\012"};
    host_u.send_line(s, hung);
    n = 0;
    while (!hung && host_u.got.size() < r.len() && n < 800) begin
      @(posedge mclk);
      n++;
    end
    if (hung || n == 800) begin
      mismatches++;
      give_verdict();
    end
    repeat (r.len() == 0 ? 80 : 6) @(posedge mclk);
    check(host_u.got.size(), r.len(), s);
    for (int i = 0; i < r.len() && i < host_u.got.size(); i++)
      check(host_u.got[i], r[i], s);
    host_u.got.delete();
  endtask
  task automatic sc_reset();
    reg_rd(8'h04, d);
    check(d, 32'h00002000, "alt reset");
    reg_rd(8'h1C, d);
    check(d[0], 1'b1, "az enable reset");
    check(bg_ppm_r, 24'h000190, "background reset");
    check(fa_ppm_r, 16'h0190, "fresh air reset");
    reg_rd(8'h20, d);
    check(d, 32'h00000000, "unmapped read");
    cmd("s", "s 08192");
  endtask
  task automatic sc_alt();
    cmd("S 65536", "S 65536");
    check(alt_r, 17'h10000, "alt max");
    cmd("S 65537", "");
    check(alt_r, 17'h10000, "alt kept");
    cmd("S 0", "S 00000");
    cmd("s", "s 00000");
    reg_wr(8'h04, 32'h00000005);
    reg_rd(8'h04, d);
    check(d, 32'h00000000, "alt read only");
  endtask
  // Host splits each level into quotient and remainder by 256
  task automatic sc_levels();
    reg_wr(8'h00, 32'h00000003);
    ce <= 1'b0;
    reg_wr(8'h00, 32'h00000009);
    ce <= 1'b1;
    reg_rd(8'h00, d);
    check(d, 32'h00000003, "frozen multiplier");
    cmd($sformatf("P 8 %0d", 400 / 256), "P 00008 00001");
    cmd($sformatf("P 9 %0d", 400 % 256), "P 00009 00144");
    reg_rd(8'h08, d);
    check(d, 32'h00000190, "background raw");
    check(bg_ppm_r, 24'h0004B0, "background scaled");
    cmd($sformatf("P 10 %0d", 2000 / 256), "P 00010 00007");
    cmd($sformatf("P 11 %0d", 2000 % 256), "P 00011 00208");
    check(fa_ppm_r, 16'h07D0, "fresh air level");
    cmd("P 12 1", "");
    cmd("X", "");
  endtask
  // Intervals written with one tenth digit
  task automatic sc_autozero();
    cmd("@ 2.5 3.0", "@ 00002.5 00003.0");
    check(az_init_r, 17'h00002, "initial days");
    check(az_reg_r, 17'h00003, "regular days");
    reg_rd(8'h14, d);
    check(d[27:24], 4'h5, "initial tenths");
    cmd("@ 1.25 3.0", "");
    cmd("@", "@ 00002.5 00003.0");
    cmd("@ 0", "@ 0");
    check(az_en_r, 1'b0, "auto-zero off");
    cmd("@", "@ 0");
  endtask
  // No measurement runs in this bench, so identity may follow
  task automatic sc_identity();
    host_u.slow <= 1'b1;
    cmd("Y", "Y,T2.0\015\012B 00055 00000");
    host_u.slow <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sc_reset();
    sc_alt();
    sc_levels();
    sc_autozero();
    sc_identity();
    give_verdict();
  end
endmodule
bind cscp_parser cscp_props chk_u (
  .mclk(mclk), .rst(rst), .rx_ready_r(rx_ready_r),
  .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
  .addr(addr), .rd(rd), .rdata_r(rdata_r), .alt_r(alt_r),
  .az_en_r(az_en_r), .az_init_r(az_init_r), .az_reg_r(az_reg_r));
`default_nettype wire
